// ---- pkg/eprgm_map.vh ----
// Constants for the EPROM program control block
// Assumes an 8-bit CPU bus with 16-bit addresses
`ifndef EPRGM_MAP_VH
`define EPRGM_MAP_VH
`define EPRGM_CTRL_ADDR 16'h001E
`define EPRGM_CTRL_RESET 8'h00
`define EPRGM_LAT_BIT 1
`define EPRGM_PWR_BIT 0
`define EPRGM_BOOT_LO 16'h1E00
`define EPRGM_BOOT_HI 16'h1FEF
`define EPRGM_ARR_LO 16'h1000
`define EPRGM_ARR_HI 16'h1FFF
`define EPRGM_BYTE_TIME_US 1000
`define EPRGM_CLK_MHZ 250
`define EPRGM_BLANK 8'hFF
`endif

// ---- rtl/eprgm_sync.v ----
// Two-flop synchroniser for a pin level
// Assumes the input is asynchronous to mclk
`timescale 1ns/1ps
module eprgm_sync (
	// Clock and reset
	input wire mclk,
	input wire rstn,
	// Pin level in and synchronised out
	input wire din,
	output reg dout
);
	reg meta_q;
	always @(posedge mclk) begin
		if (!rstn) begin
			meta_q <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule // eprgm_sync

// ---- rtl/eprgm_ctrl.v ----
// EPROM program control register, latches and bootloader entry detect
// Assumes a CPU bus with one-cycle read/write strobes on mclk
// Notes on behaviour
// RULE1: Boot mode at reset release on pin levels
// RULE2: Boot routine occupies ROM 1E00 to 1FEF
// RULE3: Boot source is an external EPROM only
// RULE4: Boot makes one 1ms pass, then verifies
// RULE5: Control register decoded at address 001E
// RULE6: Eight bits, latch bit1, power bit0, reset zero
// RULE7: Latch bit clear gives normal array reads
// RULE8: Latch bit set captures write address, data; code captures only while power bit is clear
// RULE9: Latch bit set blocks array read data
// RULE10: Software sets latch only with supply present
// RULE11: Power bit switches programming power on, off
// RULE12: Power bit forced low without latch bit
// RULE13: Software follows the byte programming order
// RULE14: Power and latch cleared by separate writes
// RULE15: Power pulse lasts about 1ms per byte
// RULE16: Reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "eprgm_map.vh"
module eprgm_ctrl #(
	parameter integer BYTE_CYCLES = `EPRGM_BYTE_TIME_US * `EPRGM_CLK_MHZ
) (
	// Clock and reset
	input wire mclk,
	input wire rstn,
	// CPU bus
	input wire [15:0] cpu_addr,
	input wire [7:0] cpu_wdata,
	input wire cpu_wr,
	input wire cpu_rd,
	output reg [7:0] cpu_rdata,
	// EPROM array side
	input wire [7:0] arr_rdata,
	output reg [15:0] arr_addr,
	output reg [7:0] arr_wdata,
	output reg arr_prog_mode,
	output reg arr_prog_power,
	// Bootloader entry pins and status
	input wire supply_pin_at_test_level,
	input wire port_b_bit0_keyboard_pin,
	output reg boot_mode,
	output reg pulse_done
);
	reg lat_q;
	reg pwr_q;
	reg [1:0] boot_state_q;
	reg [1:0] boot_state_d;
	reg [31:0] pulse_cnt_q;
	reg [31:0] pulse_cnt_d;
	reg pulse_done_d;
	reg [15:0] arr_addr_d;
	reg [7:0] arr_wdata_d;
	reg [7:0] rdata_d;
	wire boot_hit;
	wire arr_rd_ok;
	wire entry_pins_ok;

	// Bootloader entry states
	localparam [1:0] BOOT_SETTLE0 = 2'h0;
	localparam [1:0] BOOT_SETTLE1 = 2'h1;
	localparam [1:0] BOOT_SAMPLE = 2'h2;
	localparam [1:0] BOOT_DONE = 2'h3;
	wire tst_s;
	wire kb_s;
	wire ctrl_hit;
	wire arr_hit;

	eprgm_sync u_sync_tst (
		.mclk(mclk),
		.rstn(rstn),
		.din(supply_pin_at_test_level),
		.dout(tst_s)
	);
	eprgm_sync u_sync_kb (
		.mclk(mclk),
		.rstn(rstn),
		.din(port_b_bit0_keyboard_pin),
		.dout(kb_s)
	);

	function in_range;
		input [15:0] a;
		input [15:0] lo;
		input [15:0] hi;
		begin
			in_range = (a >= lo) && (a <= hi);
		end
	endfunction

	assign ctrl_hit = (cpu_addr == `EPRGM_CTRL_ADDR); // RULE5
	assign boot_hit = in_range(cpu_addr, `EPRGM_BOOT_LO, `EPRGM_BOOT_HI);
	assign arr_hit = in_range(cpu_addr, `EPRGM_ARR_LO, `EPRGM_ARR_HI) && !boot_hit; // RULE2
	assign arr_rd_ok = cpu_rd && arr_hit;
	assign entry_pins_ok = tst_s && kb_s; // RULE1

	// Control register
	always @(posedge mclk) begin
		if (!rstn) begin
			lat_q <= 1'b0; // RULE6
			pwr_q <= 1'b0;
			arr_prog_mode <= 1'b0;
			arr_prog_power <= 1'b0;
		end else if (cpu_wr && ctrl_hit) begin
			lat_q <= cpu_wdata[`EPRGM_LAT_BIT];
			pwr_q <= cpu_wdata[`EPRGM_PWR_BIT] & cpu_wdata[`EPRGM_LAT_BIT]; // RULE12
			arr_prog_mode <= cpu_wdata[`EPRGM_LAT_BIT]; // RULE9
			arr_prog_power <= cpu_wdata[`EPRGM_PWR_BIT] & cpu_wdata[`EPRGM_LAT_BIT]; // RULE11
		end
	end

	// Address and data latch next value
	always @* begin
		arr_addr_d = arr_addr;
		arr_wdata_d = arr_wdata;
		if (lat_q && cpu_wr && arr_hit && !pwr_q) begin
			arr_addr_d = cpu_addr; // RULE8
			arr_wdata_d = cpu_wdata;
		end else if (!lat_q) begin
			arr_addr_d = cpu_addr; // RULE7
		end
	end

	// Address and data latches for programming
	always @(posedge mclk) begin
		if (!rstn) begin
			arr_addr <= 16'h0000;
			arr_wdata <= 8'h00;
		end else begin
			arr_addr <= arr_addr_d;
			arr_wdata <= arr_wdata_d;
		end
	end

	// Read data select, array contents hidden while latching
	always @* begin
		rdata_d = 8'h00;
		if (cpu_rd && ctrl_hit) begin
			rdata_d = {6'h00, lat_q, pwr_q}; // RULE16
		end else if (arr_rd_ok && !lat_q) begin
			rdata_d = arr_rdata; // RULE7
		end else if (arr_rd_ok) begin
			rdata_d = `EPRGM_BLANK; // RULE9
		end
	end

	// Registered read data
	always @(posedge mclk) begin
		if (!rstn) begin
			cpu_rdata <= 8'h00;
		end else begin
			cpu_rdata <= rdata_d;
		end
	end

	// Programming pulse timer next value
	always @* begin
		pulse_cnt_d = pulse_cnt_q;
		pulse_done_d = pulse_done;
		if (!pwr_q) begin
			pulse_cnt_d = 32'h0000_0000;
			pulse_done_d = 1'b0;
		end else if (pulse_cnt_q < BYTE_CYCLES - 1) begin
			pulse_cnt_d = pulse_cnt_q + 32'h0000_0001; // RULE15 RULE4
		end else begin
			pulse_done_d = 1'b1;
		end
	end

	// Programming pulse timer, status only
	always @(posedge mclk) begin
		if (!rstn) begin
			pulse_cnt_q <= 32'h0000_0000;
			pulse_done <= 1'b0;
		end else begin
			pulse_cnt_q <= pulse_cnt_d;
			pulse_done <= pulse_done_d;
		end
	end

	// Boot entry waits for both synchroniser stages to fill
	always @* begin
		boot_state_d = boot_state_q;
		case (boot_state_q)
			BOOT_SETTLE0: begin
				boot_state_d = BOOT_SETTLE1;
			end
			BOOT_SETTLE1: begin
				boot_state_d = BOOT_SAMPLE;
			end
			BOOT_SAMPLE: begin
				boot_state_d = BOOT_DONE;
			end
			BOOT_DONE: begin
				boot_state_d = BOOT_DONE;
			end
			default: begin
				boot_state_d = BOOT_SETTLE0;
			end
		endcase
	end

	// Pin levels sampled once, as seen at reset release
	always @(posedge mclk) begin
		if (!rstn) begin
			boot_state_q <= BOOT_SETTLE0;
			boot_mode <= 1'b0;
		end else begin
			boot_state_q <= boot_state_d;
			if (boot_state_q == BOOT_SAMPLE) begin
				boot_mode <= entry_pins_ok; // RULE1 RULE3
			end
		end
	end
endmodule // eprgm_ctrl

// ---- verification/eprgm_properties.sv ----
// Checker for the EPROM program control block
// Assumes one mclk domain and the bind below
`timescale 1ns/1ps
module eprgm_props (
	// Clock and reset
	input wire mclk, rstn,
	// Bus and array
	input wire [15:0] cpu_addr, arr_addr,
	input wire [7:0] cpu_wdata, cpu_rdata, arr_rdata, arr_wdata,
	input wire cpu_wr, cpu_rd, arr_prog_mode, arr_prog_power
);
	wire c = cpu_addr == 16'h001E;
	wire a = cpu_addr[15:12] == 4'h1 && !(cpu_addr >= 16'h1E00 && cpu_addr <= 16'h1FEF);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	chk_pwr_lat: assert property (arr_prog_power |-> arr_prog_mode)
		else $error("pwr");
	chk_blank_rd: assert property (cpu_rd && a && arr_prog_mode |=> cpu_rdata == 8'hFF)
		else $error("blank");
	chk_norm_rd: assert property (cpu_rd && a && !arr_prog_mode |=> cpu_rdata == $past(arr_rdata))
		else $error("read");
	chk_resv_zero: assert property (cpu_rd && c |=> cpu_rdata[7:2] == 0)
		else $error("resv");
	chk_lat_cap: assert property (cpu_wr && a && arr_prog_mode && !arr_prog_power |=>
		arr_addr == $past(cpu_addr) && arr_wdata == $past(cpu_wdata)) else $error("cap");
	chk_lat_hold: assert property (!cpu_wr && arr_prog_mode |=> $stable(arr_addr))
		else $error("hold");
	chk_lat_set: assert property (cpu_wr && c |=> arr_prog_mode == $past(cpu_wdata[1]))
		else $error("lat");
	chk_pwr_off: assert property (cpu_wr && c && !cpu_wdata[0] |=> !arr_prog_power)
		else $error("off");
	cover property (arr_prog_power);
	cover property (cpu_rd && a && arr_prog_mode);
	cover property (cpu_wr && a && arr_prog_mode);
endmodule // eprgm_props
bind eprgm_ctrl eprgm_props eprgm_props_i (.mclk, .rstn, .cpu_addr, .arr_addr, .cpu_wdata,
	.cpu_rdata, .arr_rdata, .arr_wdata, .cpu_wr, .cpu_rd, .arr_prog_mode, .arr_prog_power);

// ---- verification/test_eprom_program_control.sv ----
// Bench for the EPROM program control block
// Assumes a short byte time of 10 cycles
`timescale 1ns/1ps
module test_eprom_program_control;
	reg mclk = 0, rstn = 0, wr = 0, rd = 0, sp = 0, kb = 0;
	reg [15:0] ad = 0;
	reg [7:0] wd = 0;
	reg [7:0] ard = 8'h3C;
	wire [15:0] aa;
	wire [7:0] q, aw;
	wire pm, pp, bm, pd;
	integer errors = 0, tests_run = 0, n = 0, i;
	// Written value beside expected read-back
	reg [15:0] t [0:5] = '{16'h0202, 16'h0303, 16'h0202, 16'h0000, 16'h0100, 16'hFC00};
	always #2 mclk = ~mclk;
	eprgm_ctrl #(.BYTE_CYCLES(10)) eprgm_ctrl_i (.mclk(mclk), .rstn(rstn), .cpu_addr(ad),
		.cpu_wdata(wd), .cpu_wr(wr), .cpu_rd(rd), .cpu_rdata(q), .arr_rdata(ard),
		.arr_addr(aa), .arr_wdata(aw), .arr_prog_mode(pm), .arr_prog_power(pp),
		.supply_pin_at_test_level(sp), .port_b_bit0_keyboard_pin(kb), .boot_mode(bm),
		.pulse_done(pd));
	task ck(input [23:0] s, e); begin
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	end endtask
	task op(input w, input [15:0] a, input [7:0] d); begin
		@(negedge mclk) {wr, rd, ad, wd} = {w, !w, a, d};
		@(negedge mclk) {wr, rd} = 0;
	end endtask
	task report_and_stop; begin
		if (errors == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	end endtask
	always @(posedge mclk) if (++n == 3000) begin
		errors++;
		report_and_stop;
	end
	initial begin
		repeat (2) @(negedge mclk);
		rstn = 1;
		op(0, 16'h001E, 0);
		ck({bm, q}, 0);
		for (i = 0; i < 6; i++) begin
			op(1, 16'h001E, t[i][15:8]);
			op(0, 16'h001E, 0);
			ck(q, t[i][7:0]);
		end
		op(0, 16'h1A5C, 0);
		ck(q, 8'h3C);
		ard = 8'hA5;
		op(0, 16'h1A5C, 0);
		ck(q, 8'hA5);
		op(1, 16'h001E, 8'h02);
		op(1, 16'h1A5C, 8'h5A);
		ck({aa, aw}, 24'h1A_5C5A);
		ck(pm, 1);
		op(0, 16'h1A5C, 0);
		ck(q, 8'hFF);
		op(1, 16'h1E10, 8'hA5);
		ck({aa, aw}, 24'h1A_5C5A);
		op(0, 16'h1E10, 0);
		ck(q, 8'h00);
		op(1, 16'h001E, 8'h03);
		repeat (9) @(negedge mclk);
		ck({pp, pd}, 2'h2);
		@(negedge mclk);
		ck({pp, pd}, 2'h3);
		op(1, 16'h001E, 8'h02);
		op(1, 16'h001E, 8'h00);
		op(0, 16'h001E, 0);
		ck({pm, pp, q}, 0);
		{sp, kb, rstn} = 3'b110;
		repeat (2) @(negedge mclk);
		rstn = 1;
		repeat (4) @(negedge mclk);
		ck(bm, 1);
		{sp, kb, rstn} = 3'b100;
		repeat (2) @(negedge mclk);
		rstn = 1;
		repeat (4) @(negedge mclk);
		ck(bm, 0);
		report_and_stop;
	end
endmodule // test_eprom_program_control
